// >>> logic/dpsram_ctl_map.svh
`ifndef DPSRAM_CTL_MAP_SVH
`define DPSRAM_CTL_MAP_SVH
// Clock period in ns
`define DPS_CLK_NS        10
// Device timing figures in ns
`define DPS_T_RC_NS       55
`define DPS_T_AA_NS       55
`define DPS_T_DOE_NS      25
`define DPS_T_WC_NS       55
`define DPS_T_PWE_NS      30
`define DPS_T_HZWE_NS     25
`define DPS_T_SD_NS       20
`define DPS_T_HA_NS       2
`define DPS_T_BDD_NS      45
`define DPS_T_BHA_NS      30
// Output float after output-enable or select rises
`define DPS_T_HZOE_NS     25
// Least times round up, longest device delays are waited in full (round up)
`define DPS_CYC(ns)       (((ns) + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_RD_CYC        `DPS_CYC(`DPS_T_AA_NS)
`define DPS_WE_CYC        `DPS_CYC(`DPS_T_HZWE_NS + `DPS_T_SD_NS)
`define DPS_SD_CYC        `DPS_CYC(`DPS_T_SD_NS)
`define DPS_HA_CYC        `DPS_CYC(`DPS_T_HA_NS)
`define DPS_BDD_CYC       `DPS_CYC(`DPS_T_BDD_NS)
`define DPS_BUSY_CYC      `DPS_CYC(`DPS_T_BHA_NS)
// Pin synchroniser depth in clocks
`define DPS_SYNC_CYC      2
`define DPS_CNT_W         4
`endif

// >>> logic/dpsram_ctl_pkg.sv
package dpsram_ctl_pkg;
	// One host request
	typedef struct packed {
		logic        write;    // High for a write
		logic [10:0] addr;     // Word address
		logic [7:0]  data;     // Write data
	} dpsc_req_t;
	// Sequencer states, one-hot
	typedef enum logic [5:0] {
		DPSC_IDLE  = 6'h01,
		DPSC_RD    = 6'h02,
		DPSC_BUSYW = 6'h04,
		DPSC_WR    = 6'h08,
		DPSC_WHOLD = 6'h10,
		DPSC_GAP   = 6'h20
	} dpsc_state_t;
endpackage : dpsram_ctl_pkg

// >>> logic/dpsc_host.sv
`include "dpsram_ctl_map.svh"
// What this block does
// - Data setup 20 ns, held past end
// - Write-enable high on reads, 55 ns apart
// - Write cycle 55, setup 40, hold 2
// - Write pulse max of 30 or float+setup
// - Output-enable high allows 30 ns pulse; the pulse here stays float+setup
module dpsc_host #(
	parameter int ADDR_W = 11,                    // Address width
	parameter int DATA_W = 8                      // Data width
) (
	input  wire logic                      ref_clk,    // 100 MHz clock
	input  wire logic                      reset_n,    // Sync reset, low
	input  wire logic                      req_valid,  // Request offered
	input  wire dpsram_ctl_pkg::dpsc_req_t req,        // Request fields
	output logic                           req_ready,  // Request taken
	output logic                           rsp_valid,  // Access done pulse
	output logic [DATA_W-1:0]              rsp_data,   // Read data
	output logic                           mbox_irq,   // Mailbox flag seen
	output logic                           ce_n,       // Chip select, low
	output logic                           we_n,       // Write enable, low
	output logic                           oe_n,       // Output enable, low
	output logic [ADDR_W-1:0]              sram_addr,  // Address pins
	output logic [DATA_W-1:0]              dq_out,     // Data out
	output logic                           dq_oe_n,    // Data drive, low
	input  wire logic [DATA_W-1:0]         dq_in,      // Data in pins
	input  wire logic                      busy_n,     // Contention flag
	input  wire logic                      int_n       // Mailbox flag
);
	// The request struct fixes the widths; any other size cannot be carried
	if (ADDR_W + DATA_W + 1 != $bits(dpsram_ctl_pkg::dpsc_req_t) || DATA_W != $bits(req.data)) begin : g_size_chk
		$error("dpsc_host: widths must match the request fields");
	end

	// Phase lengths in clocks, all taken from the timing map
	localparam logic [3:0] RD_C    = 4'(`DPS_RD_CYC);              // Access time
	localparam logic [3:0] WE_C    = 4'(`DPS_WE_CYC);              // Write pulse
	localparam logic [3:0] HA_C    = 4'(`DPS_HA_CYC);              // Address hold
	localparam logic [3:0] BDD_C   = 4'(`DPS_BDD_CYC);             // Data after busy release
	localparam logic [3:0] GAP_C   = 4'(`DPS_CYC(`DPS_T_WC_NS) - `DPS_WE_CYC - `DPS_HA_CYC);
	localparam logic [3:0] SYNC_C  = 4'(`DPS_SYNC_CYC);            // Two-flop pin delay
	localparam logic [3:0] FLT_C   = 4'(`DPS_CYC(`DPS_T_HZOE_NS)); // Device output float
	// A read's drivers may still be on for the float time after output-enable rises,
	// so the gap covers it before the next write drives dq; writes pay a few idle clocks
	localparam logic [3:0] GAP_END = (GAP_C > FLT_C) ? GAP_C : FLT_C;

	// Pin synchronisers: first stage read only by second
	logic [DATA_W-1:0] dq_s1, dq_s2;
	logic              busy_s1, busy_s2, int_s1, int_s2;
	always_ff @(posedge ref_clk) begin
		dq_s1   <= dq_in;
		dq_s2   <= dq_s1;
		busy_s1 <= busy_n;
		busy_s2 <= busy_s1;
		int_s1  <= int_n;
		int_s2  <= int_s1;
	end

	dpsram_ctl_pkg::dpsc_state_t state, next_state;
	logic [3:0]        cnt, next_cnt;             // Phase timer
	logic              next_ce_n, next_we_n, next_oe_n, next_dq_oe_n;
	logic [ADDR_W-1:0] next_addr;
	logic [DATA_W-1:0] next_dq_out, next_rsp_data;
	logic              next_rsp_valid, next_req_ready, next_irq;

	// Sequencer next values
	always_comb begin
		next_state     = state;
		next_cnt       = cnt;
		next_ce_n      = ce_n;
		next_we_n      = we_n;
		next_oe_n      = oe_n;
		next_dq_oe_n   = dq_oe_n;
		next_addr      = sram_addr;
		next_dq_out    = dq_out;
		next_rsp_data  = rsp_data;
		next_rsp_valid = 1'b0;
		next_req_ready = 1'b0;
		next_irq       = ~int_s2;                 // Flag from device, level
		unique case (state)
			dpsram_ctl_pkg::DPSC_IDLE: begin
				next_ce_n = 1'b1;                 // Idle deselect gives standby
				next_oe_n = 1'b1;
				next_we_n = 1'b1;
				if (req_valid && !req_ready) begin
					next_req_ready = 1'b1;
					next_addr      = req.addr;    // Address set on the same clock as the strobes
					next_dq_out    = req.data;
					next_cnt       = 4'h0;
					next_ce_n      = 1'b0;        // Select resumes with no wait
					if (req.write) begin
						next_we_n    = 1'b0;      // Write-enable with select keeps device off bus
						next_oe_n    = 1'b1;      // Output-enable high: short pulse allowed
						next_dq_oe_n = 1'b0;
						next_state   = dpsram_ctl_pkg::DPSC_WR;
					end else begin
						next_we_n  = 1'b1;        // Reads keep write-enable high
						next_oe_n  = 1'b0;
						next_state = dpsram_ctl_pkg::DPSC_RD;
					end
				end
			end
			dpsram_ctl_pkg::DPSC_RD: begin
				next_cnt = cnt + 4'h1;
				// Busy low means the far port won the word, whichever came first
				if (!busy_s2) begin
					next_cnt   = 4'h0;            // Blocked: data frozen while busy
					next_state = dpsram_ctl_pkg::DPSC_BUSYW;
				end else if (cnt == RD_C + SYNC_C) begin
					// Address stays put past this sample, so old-data hold is never relied on
					next_rsp_data  = dq_s2;       // Past access time plus sync
					next_rsp_valid = 1'b1;        // Reads on mailbox clear own flag
					next_ce_n      = 1'b1;
					next_oe_n      = 1'b1;        // Device floats within its delay
					next_cnt       = 4'h0;
					next_state     = dpsram_ctl_pkg::DPSC_GAP;
				end
			end
			dpsram_ctl_pkg::DPSC_BUSYW: begin
				next_cnt = busy_s2 ? cnt + 4'h1 : 4'h0;
				if (cnt == BDD_C + SYNC_C) begin
					next_rsp_data  = dq_s2;       // Valid after busy release
					next_rsp_valid = 1'b1;
					next_ce_n      = 1'b1;
					next_oe_n      = 1'b1;
					next_cnt       = 4'h0;
					next_state     = dpsram_ctl_pkg::DPSC_GAP;
				end
			end
			dpsram_ctl_pkg::DPSC_WR: begin
				next_cnt = cnt + 4'h1;
				// Pulse covers float plus setup and the 30 ns floor
				if (cnt == WE_C - 4'h1) begin
					next_we_n  = 1'b1;            // Write ends on write-enable rise
					next_cnt   = 4'h0;
					next_state = dpsram_ctl_pkg::DPSC_WHOLD;
				end
			end
			dpsram_ctl_pkg::DPSC_WHOLD: begin
				next_cnt = cnt + 4'h1;
				if (cnt == HA_C - 4'h1) begin
					next_ce_n      = 1'b1;        // Address held past end
					next_dq_oe_n   = 1'b1;        // Data hold past end
					next_rsp_valid = 1'b1;        // Mailbox write raises far flag
					next_cnt       = 4'h0;
					next_state     = dpsram_ctl_pkg::DPSC_GAP;
				end
			end
			dpsram_ctl_pkg::DPSC_GAP: begin
				next_cnt = cnt + 4'h1;
				if (cnt >= GAP_END) begin
					next_state = dpsram_ctl_pkg::DPSC_IDLE; // Cycle spacing at least 55 ns
				end
			end
			default: begin
				next_state = dpsram_ctl_pkg::DPSC_IDLE;
			end
		endcase
	end

	// Register stage
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state     <= dpsram_ctl_pkg::DPSC_IDLE;
			cnt       <= 4'h0;
			ce_n      <= 1'b1;
			we_n      <= 1'b1;
			oe_n      <= 1'b1;
			dq_oe_n   <= 1'b1;
			sram_addr <= '0;
			dq_out    <= '0;
			rsp_data  <= '0;
			rsp_valid <= 1'b0;
			req_ready <= 1'b0;
			mbox_irq  <= 1'b0;
		end else begin
			state     <= next_state;
			cnt       <= next_cnt;
			ce_n      <= next_ce_n;
			we_n      <= next_we_n;
			oe_n      <= next_oe_n;
			dq_oe_n   <= next_dq_oe_n;
			sram_addr <= next_addr;
			dq_out    <= next_dq_out;
			rsp_data  <= next_rsp_data;
			rsp_valid <= next_rsp_valid;
			req_ready <= next_req_ready;
			mbox_irq  <= next_irq;
		end
	end

	// Checks on driven pins
	// Write strobe only inside select, with data driven
	a_write_strobe: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!we_n |-> !ce_n && !dq_oe_n) else $error("write-enable low outside select");
	// Reads never lower write-enable
	a_read_we_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!oe_n |-> we_n) else $error("read with write-enable low");
	// Write strobe held for float plus setup, five clocks of the write phase
	sequence s_we_pulse;
		!we_n [*5];
	endsequence
	a_pulse_width: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$fell(we_n) |-> s_we_pulse) else $error("write pulse short");
	// Data and address still stand when the write ends
	a_data_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(we_n) |-> !dq_oe_n && $stable(sram_addr)) else $error("hold lost");
	// Host never drives dq while the device outputs are enabled
	a_bus_clash: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!oe_n |-> dq_oe_n) else $error("host drives during read");
	// Host drives dq only after the device outputs had their float time, three clocks
	a_float_gap: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$fell(dq_oe_n) |-> $past(oe_n, 1) && $past(oe_n, 2) && $past(oe_n, 3))
		else $error("host drives before read outputs float");
endmodule : dpsc_host

// >>> tb/dpsc_sram_model.sv
// One port of the shared memory, seen from the controller's pins
module dpsc_sram_model #(
	parameter int          ACC_NS    = 45,     // Output delay, below the 55 ns access
	parameter logic [10:0] MBOX_ADDR = 11'h7FE // Mailbox word owned by this port
) (
	input  wire logic        ref_clk,   // Bench clock, only to remember the last output
	input  wire logic        ce_n,      // Chip select, low
	input  wire logic        we_n,      // Write enable, low
	input  wire logic        oe_n,      // Output enable, low
	input  wire logic [10:0] sram_addr, // Address pins
	input  wire logic [7:0]  dq_out,    // Data from the controller
	output wire logic [7:0]  dq_in,     // Data toward the controller
	input  wire logic        other_wr,  // Far port writes our mailbox
	output wire logic        int_n      // Mailbox flag, low
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:2047]; // Storage array
	logic [7:0] last = 8'h00; // Last driven byte
	logic       int_q = 1'b1; // Mailbox flag state
	wire        wr_act = !ce_n && !we_n;          // Write overlap
	wire        rd_act = !ce_n && !oe_n && we_n; // Drivers enabled
	// The overlap's end commits the byte
	always @(negedge wr_act) mem[sram_addr] = dq_out;
	// Remember what was driven so a released bus shows its inverse
	always @(posedge ref_clk) if (rd_act) last <= mem[sram_addr];
	// Floating bus is never the old value, so stale sampling shows
	assign #(ACC_NS) dq_in = rd_act ? mem[sram_addr] : ~last;
	// Far port write raises, own read of the mailbox clears
	always @(posedge other_wr) int_q = 1'b0;
	always @(negedge rd_act) if (sram_addr == MBOX_ADDR) int_q = 1'b1;
	assign int_n = int_q;
endmodule : dpsc_sram_model

// >>> tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, busy_n = 1'b1, other_wr = 1'b0; // Bench drives
	dpsram_ctl_pkg::dpsc_req_t req = '0; // Request fields
	logic req_ready, rsp_valid, mbox_irq, ce_n, we_n, oe_n, dq_oe_n, int_n; // Design and model outputs
	logic [7:0] rsp_data, dq_out, dq_in, q; // Data paths
	logic [10:0] sram_addr; // Address pins
	int num_errors = 0, check_count = 0; // Tallies
	always #5 ref_clk = ~ref_clk;
	dpsc_host dut (.ref_clk(ref_clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mbox_irq(mbox_irq),
		.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .sram_addr(sram_addr), .dq_out(dq_out),
		.dq_oe_n(dq_oe_n), .dq_in(dq_in), .busy_n(busy_n), .int_n(int_n));
	dpsc_sram_model mem (.ref_clk(ref_clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .sram_addr(sram_addr),
		.dq_out(dq_out), .dq_in(dq_in), .other_wr(other_wr), .int_n(int_n));
	task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk8
	task automatic chk1(string n, logic e, logic g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %b seen %b", n, e, g);
		end
	endtask : chk1
	// One request; while busy is held no answer may appear, then busy is let go
	task automatic access(logic wr, logic [10:0] a, logic [7:0] d, int hold, output logic [7:0] r);
		int n;
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req <= '{write: wr, addr: a, data: d};
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (req_ready !== 1'b1 && n < 20);
		chk1("req_ready", 1'b1, req_ready);
		req_valid <= 1'b0;
		repeat (hold) begin
			@(posedge ref_clk);
			if (rsp_valid === 1'b1) chk1("early rsp_valid", 1'b0, rsp_valid);
		end
		if (hold > 0) busy_n <= 1'b1;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 12) begin
			@(posedge ref_clk);
			n++;
		end
		chk1("rsp_valid", 1'b1, rsp_valid);
		r = rsp_data;
	endtask : access
	// Writes at both ends of the plain area, a write straight after a read, all read back
	task automatic t_write_read;
		access(1'b1, 11'h000, 8'hA5, 0, q);
		access(1'b1, 11'h7FD, 8'h5A, 0, q);
		access(1'b0, 11'h7FD, 8'h00, 0, q);
		chk8("rd 7FD", 8'h5A, q);
		access(1'b1, 11'h001, 8'h3C, 0, q);
		access(1'b0, 11'h000, 8'h00, 0, q);
		chk8("rd 000", 8'hA5, q);
		access(1'b0, 11'h001, 8'h00, 0, q);
		chk8("rd 001", 8'h3C, q);
	endtask : t_write_read
	// Contention flag low before the read; data only after its release
	task automatic t_busy;
		busy_n <= 1'b0;
		access(1'b0, 11'h000, 8'h00, 20, q);
		chk8("rd busy", 8'hA5, q);
	endtask : t_busy
	// Far port posts to our mailbox, our read of it clears the flag
	task automatic t_mbox;
		chk1("irq idle", 1'b0, mbox_irq);
		@(posedge ref_clk);
		other_wr <= 1'b1;
		@(posedge ref_clk);
		other_wr <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk1("irq set", 1'b1, mbox_irq);
		access(1'b0, 11'h7FE, 8'h00, 0, q);
		repeat (6) @(posedge ref_clk);
		chk1("irq clear", 1'b0, mbox_irq);
	endtask : t_mbox
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out
	initial begin
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_write_read();
		t_busy();
		t_mbox();
		close_out();
	end
	// Whole run needs about 155 cycles; twenty times that can only be a hang
	initial begin
		repeat (3000) @(posedge ref_clk);
		num_errors++;
		close_out();
	end
endmodule : tb
